// ---- pfi_fabric_if.sv ----
// 64b/66b PCS fabric interface: TX/RX FIFOs, encode, scramble, decode, APB registers
`timescale 1ns/100ps
`include "pfi_map.svh"

module pfi_fabric_if (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  // User transmit side
  input wire logic [63:0] tx_payload_word,
  input wire logic [7:0] tx_control,
  input wire logic tx_fifo_wr,
  input wire logic tx_frcpkt,
  output logic [3:0] tx_fifo_status,
  // Transmit gearbox side
  output pfi_pkg::pfi_blk_t gb_tx_block,
  output logic gb_tx_valid,
  input wire logic gb_tx_ready,
  // Receive line side (after gearbox and sync)
  input wire pfi_pkg::pfi_blk_t ln_rx_block,
  input wire logic ln_rx_valid,
  // User receive side
  input wire logic rx_read,
  output logic [63:0] rx_payload_word,
  output logic [7:0] rx_control,
  output logic rx_data_valid,
  output logic [1:0] rx_fifo_add,
  output logic [1:0] rx_fifo_del,
  output logic [3:0] rx_fifo_status
);

  // Encoder: all-data words get the data header, others a control header
  function automatic pfi_pkg::pfi_blk_t pfi_encode(input pfi_pkg::pfi_word_t w);
    pfi_pkg::pfi_blk_t b;
    b.hdr = (w.ctrl == 8'h00) ? `PFI_HDR_DATA : `PFI_HDR_CTRL;
    b.payload = (w.ctrl == 8'h00) ? w.data : {w.data[63:8], w.ctrl};
    return b;
  endfunction : pfi_encode

  // Self-synchronous scrambler x^58 + x^39 + 1, returns {next state, data}
  function automatic logic [121:0] pfi_scramble(input logic [57:0] st, input logic [63:0] din);
    logic [57:0] s;
    logic [63:0] q;
    s = st;
    q = 64'h0;
    for (int i = 0; i < 64; i++) begin
      q[i] = din[i] ^ s[38] ^ s[57];
      s = {s[56:0], q[i]};
    end
    return {s, q};
  endfunction : pfi_scramble

  // A half word is an idle when its four bytes are idle characters
  function automatic logic pfi_idle_half(input logic [31:0] d, input logic [3:0] c);
    return (c == 4'hF) && (d == {4{`PFI_IDLE_BYTE}});
  endfunction : pfi_idle_half

  // Registers
  logic enc_byp_r;
  logic dec_byp_r;
  logic [`PFI_IRQ_W-1:0] irq_st_r;
  logic [`PFI_IRQ_W-1:0] irq_mask_r;
  logic [57:0] scr_r;
  // TX FIFO
  pfi_pkg::pfi_word_t tx_mem [`PFI_FIFO_DEPTH];
  logic [`PFI_FIFO_AW-1:0] tx_wp_r;
  logic [`PFI_FIFO_AW-1:0] tx_rp_r;
  logic [3:0] tx_cnt_r;
  // RX FIFO
  pfi_pkg::pfi_word_t rx_mem [`PFI_FIFO_DEPTH];
  logic [`PFI_FIFO_AW-1:0] rx_wp_r;
  logic [`PFI_FIFO_AW-1:0] rx_rp_r;
  logic [3:0] rx_cnt_r;
  // Output registers
  pfi_pkg::pfi_blk_t gb_blk_r;
  logic gb_valid_r;
  pfi_pkg::pfi_word_t rx_out_r;
  logic rx_valid_r;
  logic [1:0] rx_add_r;
  logic [1:0] rx_del_r;

  // APB decode
  wire apb_wr = psel && penable && pwrite;
  wire hit_ctrl = (paddr == `PFI_REG_CTRL);
  wire hit_stat = (paddr == `PFI_REG_STAT);
  wire hit_ist = (paddr == `PFI_REG_IRQ_STAT);
  wire hit_imask = (paddr == `PFI_REG_IRQ_MASK);
  wire unmapped = !(hit_ctrl || hit_stat || hit_ist || hit_imask);
  wire [31:0] stat_word = {16'h0, rx_cnt_r, tx_cnt_r, rx_fifo_status, tx_fifo_status};

  // TX FIFO control
  wire tx_full = (tx_cnt_r == `PFI_FIFO_DEPTH);
  wire tx_empty = (tx_cnt_r == 4'h0);
  wire tx_push = tx_fifo_wr && !tx_full;
  wire tx_pop = gb_tx_ready && !tx_frcpkt && !tx_empty;
  wire tx_ovf_ev = tx_fifo_wr && tx_full;
  wire tx_unf_ev = gb_tx_ready && !tx_frcpkt && tx_empty;
  wire pfi_pkg::pfi_word_t tx_head = tx_mem[tx_rp_r];
  wire pfi_pkg::pfi_word_t tx_in = '{ctrl: tx_control, data: tx_payload_word};

  // TX block selection
  wire pfi_pkg::pfi_blk_t tx_enc = pfi_encode(tx_head);
  wire [121:0] tx_scr = pfi_scramble(scr_r, tx_enc.payload);
  wire pfi_pkg::pfi_blk_t tx_raw = '{hdr: tx_head.ctrl[1:0], payload: tx_head.data};
  wire pfi_pkg::pfi_blk_t tx_frc = '{hdr: tx_control[1:0], payload: tx_payload_word};
  wire pfi_pkg::pfi_blk_t tx_cooked = '{hdr: tx_enc.hdr, payload: tx_scr[63:0]};
  wire pfi_pkg::pfi_blk_t tx_blk_nxt = tx_frcpkt ? tx_frc : (enc_byp_r ? tx_raw : tx_cooked);
  wire gb_valid_nxt = tx_frcpkt || tx_pop;
  wire scr_step = tx_pop && !enc_byp_r;

  // RX decode
  wire [7:0] rx_dec_ctrl = (ln_rx_block.hdr == `PFI_HDR_DATA) ? 8'h00 : `PFI_IDLE_CTRL;
  wire pfi_pkg::pfi_word_t rx_in = dec_byp_r ?
      pfi_pkg::pfi_word_t'{ctrl: {6'h00, ln_rx_block.hdr}, data: ln_rx_block.payload} :
      pfi_pkg::pfi_word_t'{ctrl: rx_dec_ctrl, data: ln_rx_block.payload};
  wire [1:0] rx_idle = {pfi_idle_half(rx_in.data[63:32], rx_in.ctrl[7:4]),
                        pfi_idle_half(rx_in.data[31:0], rx_in.ctrl[3:0])};

  // RX FIFO control with rate compensation
  wire rx_full = (rx_cnt_r == `PFI_FIFO_DEPTH);
  wire rx_empty = (rx_cnt_r == 4'h0);
  wire rx_del_ev = ln_rx_valid && !dec_byp_r && (rx_cnt_r >= `PFI_AFULL_LVL) &&
                   (rx_idle == `PFI_HALF_BOTH);
  wire rx_push = ln_rx_valid && !rx_full && !rx_del_ev;
  wire rx_ovf_ev = ln_rx_valid && rx_full && !rx_del_ev;
  wire rx_pop = rx_read && !rx_empty;
  wire rx_add_ev = rx_read && rx_empty && !dec_byp_r;
  wire rx_unf_ev = rx_read && rx_empty && dec_byp_r;
  wire pfi_pkg::pfi_word_t rx_idle_word = '{ctrl: `PFI_IDLE_CTRL, data: {8{`PFI_IDLE_BYTE}}};

  // Interrupt events; set wins over a write-one clear
  wire [`PFI_IRQ_W-1:0] irq_ev = {rx_del_ev, rx_add_ev, rx_ovf_ev, rx_unf_ev, tx_ovf_ev, tx_unf_ev};
  wire [`PFI_IRQ_W-1:0] irq_clr = (apb_wr && hit_ist) ? pwdata[`PFI_IRQ_W-1:0] : '0;
  wire [`PFI_IRQ_W-1:0] irq_st_nxt = (irq_st_r & ~irq_clr) | irq_ev;

  // Control register and interrupt state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enc_byp_r <= 1'b0;
      dec_byp_r <= 1'b0;
      irq_mask_r <= '0;
      irq_st_r <= '0;
    end else begin
      if (apb_wr && hit_ctrl) begin
        enc_byp_r <= pwdata[`PFI_CTRL_ENC_BYP];
        dec_byp_r <= pwdata[`PFI_CTRL_DEC_BYP];
      end
      if (apb_wr && hit_imask) begin
        irq_mask_r <= pwdata[`PFI_IRQ_W-1:0];
      end
      irq_st_r <= irq_st_nxt;
    end
  end

  // TX FIFO storage
  always_ff @(posedge pclk) begin
    if (tx_push) begin
      tx_mem[tx_wp_r] <= tx_in;
    end
  end

  // TX pointers, scrambler state and gearbox output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_wp_r <= '0;
      tx_rp_r <= '0;
      tx_cnt_r <= 4'h0;
      scr_r <= `PFI_SCR_RESET;
      gb_blk_r <= '0;
      gb_valid_r <= 1'b0;
    end else begin
      tx_wp_r <= tx_wp_r + {2'h0, tx_push};
      tx_rp_r <= tx_rp_r + {2'h0, tx_pop};
      tx_cnt_r <= tx_cnt_r + {3'h0, tx_push} - {3'h0, tx_pop};
      if (scr_step) begin
        scr_r <= tx_scr[121:64];
      end
      gb_blk_r <= tx_blk_nxt;
      gb_valid_r <= gb_valid_nxt;
    end
  end

  // RX FIFO storage
  always_ff @(posedge pclk) begin
    if (rx_push) begin
      rx_mem[rx_wp_r] <= rx_in;
    end
  end

  // RX pointers and user-side outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_wp_r <= '0;
      rx_rp_r <= '0;
      rx_cnt_r <= 4'h0;
      rx_out_r <= '0;
      rx_valid_r <= 1'b0;
      rx_add_r <= 2'h0;
      rx_del_r <= 2'h0;
    end else begin
      rx_wp_r <= rx_wp_r + {2'h0, rx_push};
      rx_rp_r <= rx_rp_r + {2'h0, rx_pop};
      rx_cnt_r <= rx_cnt_r + {3'h0, rx_push} - {3'h0, rx_pop};
      if (rx_pop) begin
        rx_out_r <= rx_mem[rx_rp_r];
      end else if (rx_add_ev) begin
        rx_out_r <= rx_idle_word;
      end
      rx_valid_r <= rx_pop || rx_add_ev;
      rx_add_r <= rx_add_ev ? `PFI_HALF_BOTH : 2'h0;
      rx_del_r <= rx_del_ev ? rx_idle : 2'h0;
    end
  end

  // Output drive
  assign gb_tx_block = gb_blk_r;
  assign gb_tx_valid = gb_valid_r;
  assign rx_payload_word = rx_out_r.data;
  assign rx_control = rx_out_r.ctrl;
  assign rx_data_valid = rx_valid_r;
  assign rx_fifo_add = rx_add_r;
  assign rx_fifo_del = rx_del_r;
  // FIFO flag vectors
  assign tx_fifo_status = {irq_st_r[`PFI_IRQ_TX_OVF], irq_st_r[`PFI_IRQ_TX_UNF],
                           tx_cnt_r >= `PFI_AFULL_LVL, tx_cnt_r <= `PFI_AEMPTY_LVL};
  assign rx_fifo_status = {irq_st_r[`PFI_IRQ_RX_OVF], irq_st_r[`PFI_IRQ_RX_UNF],
                           rx_cnt_r >= `PFI_AFULL_LVL, rx_cnt_r <= `PFI_AEMPTY_LVL};
  assign irq = |(irq_st_r & irq_mask_r);
  // APB answer, zero wait states
  assign pready = 1'b1;
  assign pslverr = psel && penable && unmapped;
  assign prdata = hit_ctrl ? {30'h0, dec_byp_r, enc_byp_r} :
                  hit_stat ? stat_word :
                  hit_ist ? {26'h0, irq_st_r} :
                  hit_imask ? {26'h0, irq_mask_r} : 32'h0;

  // Checks
  tx_force_pass_a: assert property (@(posedge pclk) disable iff (!presetn)
    tx_frcpkt |=> gb_tx_valid && gb_tx_block == $past(tx_frc))
    else $error("forced block not passed to gearbox");
  tx_raw_hdr_a: assert property (@(posedge pclk) disable iff (!presetn)
    tx_pop && enc_byp_r |=> gb_tx_block.hdr == $past(tx_head.ctrl[1:0]))
    else $error("bypass header not taken from flags 1:0");
  tx_enc_hdr_a: assert property (@(posedge pclk) disable iff (!presetn)
    tx_pop && !enc_byp_r |=> gb_tx_valid && gb_tx_block.hdr ==
      (($past(tx_head.ctrl) == 8'h00) ? `PFI_HDR_DATA : `PFI_HDR_CTRL))
    else $error("encoded header wrong");
  tx_fifo_store_a: assert property (@(posedge pclk) disable iff (!presetn)
    tx_fifo_wr && !tx_full && !tx_pop |=> tx_cnt_r == $past(tx_cnt_r) + 4'h1)
    else $error("tx write not stored");
  tx_ovf_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    tx_fifo_wr && tx_full |=> tx_fifo_status[`PFI_FL_OVER] && tx_fifo_status[`PFI_FL_AFULL])
    else $error("tx overflow not flagged");
  rx_hdr_byp_a: assert property (@(posedge pclk) disable iff (!presetn)
    rx_push && dec_byp_r |=> rx_mem[$past(rx_wp_r)].ctrl == {6'h00, $past(ln_rx_block.hdr)})
    else $error("rx bypass header misplaced");
  rx_valid_pop_a: assert property (@(posedge pclk) disable iff (!presetn)
    rx_read && !rx_empty |=> rx_data_valid && rx_fifo_add == 2'h0)
    else $error("rx valid missing after pop");
  rx_no_valid_a: assert property (@(posedge pclk) disable iff (!presetn)
    rx_read && rx_empty && dec_byp_r |=> !rx_data_valid ##1 rx_fifo_status[`PFI_FL_UNDER])
    else $error("rx valid with no word");
  rx_add_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    rx_add_ev |=> rx_data_valid && rx_fifo_add == `PFI_HALF_BOTH && rx_control == `PFI_IDLE_CTRL)
    else $error("rx insertion not flagged");
  rx_del_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    rx_del_ev |=> rx_fifo_del == `PFI_HALF_BOTH && rx_cnt_r <= $past(rx_cnt_r))
    else $error("rx deletion not flagged");
  irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
    tx_ovf_ev && irq_mask_r[`PFI_IRQ_TX_OVF] |=> irq)
    else $error("masked-in event gave no interrupt");

  // Forcing holds the FIFO still when nothing is written
  tx_frc_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    tx_frcpkt && !tx_fifo_wr |=> tx_cnt_r == $past(tx_cnt_r))
    else $error("fifo moved while forcing");

  // Bypass payload passes unchanged
  tx_byp_data_a: assert property (@(posedge pclk) disable iff (!presetn)
    tx_pop && enc_byp_r |=> gb_tx_block.payload == $past(tx_head.data))
    else $error("bypass payload altered");

  // Stored word keeps its lane flags
  tx_lane_store_a: assert property (@(posedge pclk) disable iff (!presetn)
    tx_push |=> tx_mem[$past(tx_wp_r)] == $past({tx_control, tx_payload_word}))
    else $error("tx word or flags not stored");

  // Pull on an empty TX FIFO flags underflow and sends no block
  tx_unf_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    tx_unf_ev |=> tx_fifo_status[`PFI_FL_UNDER] && !gb_tx_valid)
    else $error("tx underflow not flagged");

  // Write to a full RX FIFO flags overflow
  rx_ovf_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    ln_rx_valid && rx_full && !rx_del_ev |=> rx_fifo_status[`PFI_FL_OVER])
    else $error("rx overflow not flagged");

  // Bypass words leave flags 7:2 clear at the output
  rx_byp_out_a: assert property (@(posedge pclk) disable iff (!presetn)
    rx_pop && dec_byp_r |=> rx_control[7:2] == 6'h00)
    else $error("rx bypass upper flags set");

  // A deleted word is not stored
  rx_del_skip_a: assert property (@(posedge pclk) disable iff (!presetn)
    rx_del_ev && !rx_pop |=> rx_cnt_r == $past(rx_cnt_r))
    else $error("deleted word was stored");

  // Output word holds and valid stays low between pops
  rx_word_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !rx_pop && !rx_add_ev |=> $stable(rx_payload_word) && !rx_data_valid)
    else $error("rx word changed without pop");

  // Write-one clear of a quiet status bit
  irq_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    apb_wr && hit_ist && irq_ev == '0 |=> (irq_st_r & $past(pwdata[`PFI_IRQ_W-1:0])) == '0)
    else $error("status bit not cleared");

  forced_seen_c: cover property (@(posedge pclk) disable iff (!presetn) tx_frcpkt ##1 gb_tx_valid);
  tx_fill_c: cover property (@(posedge pclk) disable iff (!presetn) tx_full ##1 tx_fifo_wr);
  rx_insert_c: cover property (@(posedge pclk) disable iff (!presetn) rx_add_ev);
  rx_delete_c: cover property (@(posedge pclk) disable iff (!presetn) rx_del_ev);
  rx_over_c: cover property (@(posedge pclk) disable iff (!presetn) rx_ovf_ev);

endmodule : pfi_fabric_if

// ---- pfi_map.svh ----
// Offsets, field positions, levels and codes of the 64b/66b fabric interface
`ifndef PFI_MAP_SVH
`define PFI_MAP_SVH
// FIFO geometry and thresholds
`define PFI_FIFO_AW 3
`define PFI_FIFO_DEPTH 4'h8
`define PFI_AEMPTY_LVL 4'h2
`define PFI_AFULL_LVL 4'h6
// Flag vector bit positions
`define PFI_FL_AEMPTY 0
`define PFI_FL_AFULL 1
`define PFI_FL_UNDER 2
`define PFI_FL_OVER 3
// Block codes
`define PFI_HDR_DATA 2'h1
`define PFI_HDR_CTRL 2'h2
`define PFI_IDLE_BYTE 8'h07
`define PFI_IDLE_CTRL 8'hFF
`define PFI_HALF_BOTH 2'h3
`define PFI_SCR_RESET 58'h3FF_FFFF_FFFF_FFFF
// Register byte offsets
`define PFI_REG_CTRL 12'h000
`define PFI_REG_STAT 12'h004
`define PFI_REG_IRQ_STAT 12'h008
`define PFI_REG_IRQ_MASK 12'h00C
// Control register fields
`define PFI_CTRL_ENC_BYP 0
`define PFI_CTRL_DEC_BYP 1
// Interrupt status bits
`define PFI_IRQ_W 6
`define PFI_IRQ_TX_UNF 0
`define PFI_IRQ_TX_OVF 1
`define PFI_IRQ_RX_UNF 2
`define PFI_IRQ_RX_OVF 3
`define PFI_IRQ_RX_ADD 4
`define PFI_IRQ_RX_DEL 5
`endif

// ---- pfi_pkg.sv ----
// Types shared by the 64b/66b fabric interface
package pfi_pkg;
  // Payload word with its per-byte control flags
  typedef struct packed {
    logic [7:0] ctrl;
    logic [63:0] data;
  } pfi_word_t;
  // 66-bit block: sync header and payload
  typedef struct packed {
    logic [1:0] hdr;
    logic [63:0] payload;
  } pfi_blk_t;
endpackage : pfi_pkg

// ---- pfi_tb.sv ----
// Self-checking bench for the 64b/66b fabric interface
`timescale 1ns/100ps
`include "pfi_map.svh"
module tb;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic gb_tx_ready = 1'b0, ln_rx_valid = 1'b0, pready, pslverr, irq, errv;
  logic gb_tx_valid, rx_data_valid, tx_fifo_wr, tx_frcpkt, rx_read;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdv, seed_v;
  logic [63:0] tx_payload_word, rx_payload_word, dv, pv;
  logic [57:0] sv = '1;
  logic [7:0] tx_control, rx_control, cv;
  logic [3:0] tx_fifo_status, rx_fifo_status;
  logic [1:0] rx_fifo_add, rx_fifo_del;
  pfi_pkg::pfi_blk_t gb_tx_block;
  pfi_pkg::pfi_blk_t ln_rx_block = '0;
  logic [65:0] txq[$], txm[$];
  logic [73:0] rxq[$];
  int n_mismatch = 0, comparisons = 0, i;
  // 200 MHz clock
  always #2.5 pclk = ~pclk;
  pfi_fabric_if dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .tx_payload_word(tx_payload_word), .tx_control(tx_control),
    .tx_fifo_wr(tx_fifo_wr), .tx_frcpkt(tx_frcpkt), .tx_fifo_status(tx_fifo_status),
    .gb_tx_block(gb_tx_block), .gb_tx_valid(gb_tx_valid), .gb_tx_ready(gb_tx_ready),
    .ln_rx_block(ln_rx_block), .ln_rx_valid(ln_rx_valid), .rx_read(rx_read),
    .rx_payload_word(rx_payload_word), .rx_control(rx_control), .rx_data_valid(rx_data_valid),
    .rx_fifo_add(rx_fifo_add), .rx_fifo_del(rx_fifo_del), .rx_fifo_status(rx_fifo_status));
  pfi_user_model um (.pclk(pclk), .tx_payload_word(tx_payload_word), .tx_control(tx_control),
    .tx_fifo_wr(tx_fifo_wr), .tx_frcpkt(tx_frcpkt), .rx_read(rx_read));
  // Compare and count
  task chk(input logic [79:0] got, input logic [79:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  // Reference scrambler x^58 + x^39 + 1, bit 0 first, state in sv
  task automatic scr(input logic [63:0] d, output logic [63:0] q);
    for (int k = 0; k < 64; k++) begin
      q[k] = d[k] ^ sv[38] ^ sv[57];
      sv = {sv[56:0], q[k]};
    end
  endtask : scr
  // One APB transfer; read data and error land in rdv and errv
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Line block for one cycle, then inverted stale value
  task line(input pfi_pkg::pfi_blk_t b);
    @(posedge pclk);
    ln_rx_block <= b;
    ln_rx_valid <= 1'b1;
    @(posedge pclk);
    ln_rx_valid <= 1'b0;
    ln_rx_block <= ~b;
  endtask : line
  // Gearbox pulls n words
  task drain(input int n);
    @(posedge pclk);
    gb_tx_ready <= 1'b1;
    repeat (n) @(posedge pclk);
    gb_tx_ready <= 1'b0;
  endtask : drain
  // Settled status check
  task stat(input logic [3:0] t, input logic [3:0] r);
    @(negedge pclk);
    chk({76'h0, tx_fifo_status}, {76'h0, t}, "tx status");
    chk({76'h0, rx_fifo_status}, {76'h0, r}, "rx status");
  endtask : stat
  // Verdict
  task final_report;
    $display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  // Gearbox and RX monitor takes the oldest noted block or word
  always @(negedge pclk) begin
    if (gb_tx_valid === 1'b1) begin
      if (txq.size() == 0) chk(80'h1, 80'h0, "unexpected block");
      else chk({14'h0, gb_tx_block & txm.pop_front()}, {14'h0, txq.pop_front()}, "tx block");
    end
    if (rx_data_valid === 1'b1) begin
      if (rxq.size() == 0) chk(80'h1, 80'h0, "unexpected rx word");
      else chk({6'h0, rx_fifo_add, rx_control, rx_payload_word}, {6'h0, rxq.pop_front()}, "rx");
    end
  end
  // Watchdog
  initial begin
    repeat (5000) @(posedge pclk);
    n_mismatch++;
    final_report();
  end
  // Main sequence
  initial begin
    seed_v = $urandom(32'hD7D8);
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    stat(4'h1, 4'h1);
    apb(1'b0, 12'h010, 32'h0);
    chk({79'h0, errv}, 80'h1, "unmapped err");
    apb(1'b0, `PFI_REG_STAT, 32'h0);
    chk({48'h0, rdv}, 80'h11, "stat reg");
    // Raw forcing straight to the gearbox
    for (i = 0; i < 4; i++) begin
      dv = {$urandom, $urandom};
      cv = 8'($urandom);
      txq.push_back({cv[1:0], dv});
      txm.push_back({66{1'b1}});
      um.send(dv, cv, 1'b0, 1'b1);
    end
    // Normal path: header follows the flags, payload scrambled
    for (i = 0; i < 2; i++) begin
      dv = {$urandom, $urandom};
      scr(i[0] ? {dv[63:8], 8'h01} : dv, pv);
      txq.push_back({i[0] ? 2'h2 : 2'h1, pv});
      txm.push_back({66{1'b1}});
      um.send(dv, {7'h0, i[0]}, 1'b1, 1'b0);
      drain(1);
    end
    // Encoder bypass, overflow, interrupt, underflow
    apb(1'b1, `PFI_REG_CTRL, 32'h1);
    apb(1'b1, `PFI_REG_IRQ_MASK, 32'h3F);
    for (i = 0; i < 9; i++) begin
      dv = {$urandom, $urandom};
      cv = 8'($urandom);
      if (i < 8) txq.push_back({cv[1:0], dv});
      if (i < 8) txm.push_back({66{1'b1}});
      um.send(dv, cv, 1'b1, 1'b0);
    end
    stat(4'hA, 4'h1);
    chk({79'h0, irq}, 80'h1, "irq set");
    apb(1'b1, `PFI_REG_IRQ_STAT, 32'h3F);
    stat(4'h2, 4'h1);
    drain(9);
    stat(4'h5, 4'h1);
    apb(1'b1, `PFI_REG_IRQ_STAT, 32'h3F);
    @(negedge pclk);
    chk({79'h0, irq}, 80'h0, "irq clear");
    apb(1'b0, `PFI_REG_IRQ_MASK, 32'h0);
    chk({48'h0, rdv}, 80'h3F, "mask reg");
    // Decoder bypass: header on flags 1:0, then empty pull
    apb(1'b1, `PFI_REG_CTRL, 32'h3);
    for (i = 0; i < 3; i++) begin
      dv = {$urandom, $urandom};
      cv = 8'($urandom);
      rxq.push_back({2'h0, 6'h0, cv[1:0], dv});
      line({cv[1:0], dv});
    end
    repeat (4) um.pull();
    stat(4'h1, 4'h5);
    apb(1'b1, `PFI_REG_IRQ_STAT, 32'h3F);
    // Normal decode and idle insertion on empty pull
    apb(1'b1, `PFI_REG_CTRL, 32'h0);
    dv = {$urandom, $urandom};
    rxq.push_back({2'h0, 8'h00, dv});
    rxq.push_back({2'h0, 8'hFF, ~dv});
    rxq.push_back({2'h3, 8'hFF, 64'h0707070707070707});
    line({2'h1, dv});
    line({2'h2, ~dv});
    repeat (3) um.pull();
    // Six stored words, then an idle word is deleted
    for (i = 0; i < 6; i++) begin
      dv = {$urandom, $urandom};
      rxq.push_back({2'h0, 8'h00, dv});
      line({2'h1, dv});
    end
    stat(4'h1, 4'h2);
    line({2'h2, 64'h0707070707070707});
    @(negedge pclk);
    chk({78'h0, rx_fifo_del}, 80'h3, "idle deleted");
    // Fill to eight, the ninth word overflows
    for (i = 0; i < 3; i++) begin
      dv = {$urandom, $urandom};
      if (i < 2) rxq.push_back({2'h0, 8'h00, dv});
      line({2'h1, dv});
    end
    stat(4'h1, 4'hA);
    repeat (8) um.pull();
    repeat (5) @(posedge pclk);
    chk(80'(txq.size() + rxq.size()), 80'h0, "notes left");
    final_report();
  end
endmodule : tb

// ---- pfi_user_model.sv ----
// Fabric-side user model: pushes transmit words and pulls receive words
`timescale 1ns/100ps
module pfi_user_model (
  // Clock
  input wire logic pclk,
  // User transmit and receive strobes
  output logic [63:0] tx_payload_word,
  output logic [7:0] tx_control,
  output logic tx_fifo_wr,
  output logic tx_frcpkt,
  output logic rx_read
);
  // Quiet lines at time zero
  initial begin
    tx_payload_word = 64'h0;
    tx_control = 8'h00;
    tx_fifo_wr = 1'b0;
    tx_frcpkt = 1'b0;
    rx_read = 1'b0;
  end
  // One word for one cycle; released word and flag lines show the inverse so stale data never matches, strobes drop low
  task send(input logic [63:0] d, input logic [7:0] c, input logic wr, input logic frc);
    @(posedge pclk);
    tx_payload_word <= d;
    tx_control <= c;
    tx_fifo_wr <= wr;
    tx_frcpkt <= frc;
    @(posedge pclk);
    tx_payload_word <= ~d;
    tx_control <= ~c;
    tx_fifo_wr <= 1'b0;
    tx_frcpkt <= 1'b0;
  endtask : send
  // One pull strobe
  task pull;
    @(posedge pclk);
    rx_read <= 1'b1;
    @(posedge pclk);
    rx_read <= 1'b0;
  endtask : pull
endmodule : pfi_user_model
